// File: core/psod_pkg.sv
// Package for the PLL status and output driver register bank
package psod_pkg;

    // Register addresses on the serial port
    localparam logic [9:0] ADDR_MON_ENABLE = 10'h01A;
    localparam logic [9:0] ADDR_POWER_DOWN = 10'h01C;
    localparam logic [9:0] ADDR_PLL_STATUS = 10'h01F;
    localparam logic [9:0] ADDR_DRV_ZERO = 10'h0F0;
    localparam logic [9:0] ADDR_DRV_ONE = 10'h0F1;
    localparam logic [9:0] ADDR_DRV_TWO = 10'h0F2;

    // Field positions
    localparam int BIT_SEL_REF = 4;
    localparam int BIT_FB_PRESENT = 3;
    localparam int BIT_REFERENCE_INPUT_SECOND_PRESENT = 2;
    localparam int BIT_REFERENCE_INPUT_FIRST_PRESENT = 1;
    localparam int BIT_LOCK = 0;
    localparam int BIT_MON_FB_EN = 7;
    localparam int BIT_MON_REFERENCE_INPUT_FIRST_EN = 6;
    localparam int BIT_MON_REFERENCE_INPUT_SECOND_EN = 5;
    localparam int BIT_REFERENCE_INPUT_SECOND_CLK_OFF = 5;
    localparam int BIT_REFERENCE_INPUT_FIRST_CLK_OFF = 4;
    localparam int BIT_PAIR_PD = 4;
    localparam int BIT_DRV_PD = 0;

    // Reset values
    localparam logic [7:0] RST_DRIVER = 8'h04;
    localparam logic [7:0] RST_MON_ENABLE = 8'h00;
    localparam logic [7:0] RST_POWER_DOWN = 8'h22;

    // Swing codes
    localparam logic [1:0] SWING_400MV = 2'h0;
    localparam logic [1:0] SWING_600MV = 2'h1;
    localparam logic [1:0] SWING_780MV = 2'h2;
    localparam logic [1:0] SWING_960MV = 2'h3;

    // Analog status inputs travel together
    typedef struct packed {
        logic sel_ref_second;
        logic fb_present;
        logic ref_second_present;
        logic ref_first_present;
        logic lock;
    } psod_status_type;

    // Per-driver control outputs
    typedef struct packed {
        logic [1:0] swing;
        logic power_down;
    } psod_drv_type;

endpackage

// File: core/psod_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous status
`timescale 1ns/1ps
`default_nettype none
module psod_sync #(
    parameter int WIDTH = 5
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] out_q;

    // Stage one only feeds stage two; output moves when two and three agree
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            out_q <= '0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            out_q <= (s2_q & s3_q) | (out_q & (s2_q | s3_q));
        end
    end

    assign sync_out = out_q;
endmodule
`default_nettype wire

// File: core/psod_regs.sv
// PLL status readback and first three output driver control registers
// How it works
// - Status bit 4 shows selected reference
// - Bit 3 feedback present, gated by monitor enable
// - Bit 2 second reference present when monitored
// - Bit 1 first reference present when monitored
// - Bit 0 shows digital lock detector
// - Driver zero bit 4 powers channels 0,1
// - Driver two bit 4 powers channels 2,3
// - Bits 2:1 select swing, default 780mV
// - Bit 0 powers down single driver
// - Second reference monitor clock off blocks switchover
`timescale 1ns/1ps
`default_nettype none
module psod_regs #(
    parameter int NUM_DRIVERS = 3
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [9:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    input wire psod_pkg::psod_status_type status_in,
    output logic [NUM_DRIVERS-1:0] drv_power_down,
    output logic [2*NUM_DRIVERS-1:0] drv_swing,
    output logic [3:0] channel_power_down,
    output logic [7:0] mon_enable,
    output logic [7:0] power_down_ctrl,
    output logic auto_switch_allowed
);
    // Pair mapping below is fixed to drivers zero and two, so refuse other counts
    generate
        if (NUM_DRIVERS != 3) begin : g_bad_count
            $error("psod_regs serves exactly three drivers");
        end
    endgenerate

    // Decode one address match, used many times
    function automatic logic hit(input logic [9:0] a, input logic [9:0] b);
        return a == b;
    endfunction

    logic [7:0] drv_q [NUM_DRIVERS];
    logic [7:0] mon_q;
    logic [7:0] pd_q;
    logic [7:0] rdata_q;
    logic [NUM_DRIVERS-1:0] drv_pd_q;
    logic [2*NUM_DRIVERS-1:0] swing_q;
    logic [3:0] chan_pd_q;
    logic auto_q;
    logic [4:0] st_sync;
    psod_pkg::psod_status_type st;

    // Status pins come from analog clocks, so synchronise them
    psod_sync #(.WIDTH(5)) u_sync (
        .clock(clock),
        .rst(rst),
        .async_in(status_in),
        .sync_out(st_sync)
    );
    assign st = psod_pkg::psod_status_type'(st_sync);

    // Presence bits are qualified by monitor state
    wire fb_valid = mon_q[psod_pkg::BIT_MON_FB_EN];
    wire reference_input_second_valid = mon_q[psod_pkg::BIT_MON_REFERENCE_INPUT_SECOND_EN] & ~pd_q[psod_pkg::BIT_REFERENCE_INPUT_SECOND_CLK_OFF];
    wire reference_input_first_valid = mon_q[psod_pkg::BIT_MON_REFERENCE_INPUT_FIRST_EN] & ~pd_q[psod_pkg::BIT_REFERENCE_INPUT_FIRST_CLK_OFF];
    wire bit_sel = st.sel_ref_second;
    wire bit_fb = st.fb_present & fb_valid;
    wire bit_reference_input_second = st.ref_second_present & reference_input_second_valid;
    wire bit_reference_input_first = st.ref_first_present & reference_input_first_valid;
    wire bit_lock = st.lock;
    wire [7:0] status_word = {3'h0, bit_sel, bit_fb, bit_reference_input_second, bit_reference_input_first, bit_lock};

    // Read multiplexer; unmapped addresses read zero.
    // Status is sampled from the synchronised copy, so a pin change shows
    // up in a read only after the filter has seen two agreeing samples.
    // Writes to the status address fall through every write decode below,
    // which keeps that register read-only without any extra logic.
    wire [7:0] rd_mux = hit(addr, psod_pkg::ADDR_PLL_STATUS) ? status_word :
                        hit(addr, psod_pkg::ADDR_MON_ENABLE) ? mon_q :
                        hit(addr, psod_pkg::ADDR_POWER_DOWN) ? pd_q :
                        hit(addr, psod_pkg::ADDR_DRV_ZERO) ? drv_q[0] :
                        hit(addr, psod_pkg::ADDR_DRV_ONE) ? drv_q[1] :
                        hit(addr, psod_pkg::ADDR_DRV_TWO) ? drv_q[2] : 8'h00;

    // Monitor and power-down control writes
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mon_q <= psod_pkg::RST_MON_ENABLE;
            pd_q <= psod_pkg::RST_POWER_DOWN;
        end else begin
            if (wr_en && hit(addr, psod_pkg::ADDR_MON_ENABLE)) begin
                mon_q <= wdata;
            end
            if (wr_en && hit(addr, psod_pkg::ADDR_POWER_DOWN)) begin
                pd_q <= wdata;
            end
        end
    end

    // Per-driver write decode, one address match per driver
    logic [NUM_DRIVERS-1:0] drv_hit;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_DRIVERS; gi++) begin : g_drv
            localparam logic [9:0] DRV_ADDR = psod_pkg::ADDR_DRV_ZERO + 10'(gi);
            assign drv_hit[gi] = wr_en && hit(addr, DRV_ADDR);
            // swing of each driver follows its write
            swing_each_a: assert property (@(posedge clock) disable iff (rst)
                drv_hit[gi] |=> ##1 drv_swing[2*gi +: 2] == $past(wdata[2:1], 2))
                else $error("driver swing wrong");
            // power-down of each driver follows its write
            drv_pd_each_a: assert property (@(posedge clock) disable iff (rst)
                drv_hit[gi] |=> ##1 drv_power_down[gi] == $past(wdata[0], 2))
                else $error("driver power-down wrong");
        end
    endgenerate

    // Driver registers and their output flops in one process, so that every
    // vector has a single driver; don't-care bits are stored as written
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_DRIVERS; i++) begin
                drv_q[i] <= psod_pkg::RST_DRIVER;
            end
            drv_pd_q <= '0;
            swing_q <= {NUM_DRIVERS{psod_pkg::SWING_780MV}};
        end else begin
            for (int i = 0; i < NUM_DRIVERS; i++) begin
                if (drv_hit[i]) begin
                    drv_q[i] <= wdata;
                end
                drv_pd_q[i] <= drv_q[i][psod_pkg::BIT_DRV_PD];
                swing_q[2*i +: 2] <= drv_q[i][2:1];
            end
        end
    end

    // channel pair power-down; driver one bit 4 reserved, unused
    wire pair01 = drv_q[0][psod_pkg::BIT_PAIR_PD];
    wire pair23 = drv_q[2][psod_pkg::BIT_PAIR_PD];
    // switchover needs both reference monitor clocks running
    wire auto_d = ~pd_q[psod_pkg::BIT_REFERENCE_INPUT_SECOND_CLK_OFF] & ~pd_q[psod_pkg::BIT_REFERENCE_INPUT_FIRST_CLK_OFF];

    // Output flops
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
            chan_pd_q <= 4'h0;
            auto_q <= 1'b0;
        end else begin
            if (rd_en) begin
                rdata_q <= rd_mux;
            end
            chan_pd_q <= {pair23, pair23, pair01, pair01};
            auto_q <= auto_d;
        end
    end

    assign rdata = rdata_q;
    assign drv_power_down = drv_pd_q;
    assign drv_swing = swing_q;
    assign channel_power_down = chan_pd_q;
    assign mon_enable = mon_q;
    assign power_down_ctrl = pd_q;
    assign auto_switch_allowed = auto_q;

    // Checks: reads land one edge after rd_en, driver outputs two edges
    // after wr_en, since each driver field passes its register and then
    // the output flop. The properties allow for exactly that latency.
    wire stat_rd = rd_en && hit(addr, psod_pkg::ADDR_PLL_STATUS);
    sel_ref_rd_a: assert property (@(posedge clock) disable iff (rst)
        stat_rd |=> rdata[4] == $past(bit_sel))
        else $error("selected reference bit wrong");
    fb_gate_a: assert property (@(posedge clock) disable iff (rst)
        stat_rd && !mon_q[7] |=> !rdata[3])
        else $error("feedback bit not gated");
    fb_show_a: assert property (@(posedge clock) disable iff (rst)
        stat_rd && mon_q[7] |=> rdata[3] == $past(st.fb_present))
        else $error("feedback bit not shown");
    reference_input_second_gate_a: assert property (@(posedge clock) disable iff (rst)
        stat_rd && pd_q[5] |=> !rdata[2])
        else $error("second reference bit not gated");
    reference_input_second_show_a: assert property (@(posedge clock) disable iff (rst)
        stat_rd && reference_input_second_valid |=> rdata[2] == $past(st.ref_second_present))
        else $error("second reference bit not shown");
    reference_input_first_gate_a: assert property (@(posedge clock) disable iff (rst)
        stat_rd && !mon_q[6] |=> !rdata[1])
        else $error("first reference bit not gated");
    // first reference gated by its clock-off bit
    reference_input_first_off_a: assert property (@(posedge clock) disable iff (rst)
        stat_rd && pd_q[4] |=> !rdata[1])
        else $error("first reference bit shown with clock off");
    reference_input_first_show_a: assert property (@(posedge clock) disable iff (rst)
        stat_rd && reference_input_first_valid |=> rdata[1] == $past(st.ref_first_present))
        else $error("first reference bit not shown");
    lock_rd_a: assert property (@(posedge clock) disable iff (rst)
        stat_rd |=> rdata[0] == $past(st.lock))
        else $error("lock bit wrong");
    rd_hold_a: assert property (@(posedge clock) disable iff (rst)
        !rd_en |=> $stable(rdata))
        else $error("read data moved without a read");
    // Status address is read-only; a write there leaves mon_enable unchanged
    status_ro_a: assert property (@(posedge clock) disable iff (rst)
        wr_en && hit(addr, psod_pkg::ADDR_PLL_STATUS) |=> $stable(mon_enable))
        else $error("status write changed a control");
    mon_wr_a: assert property (@(posedge clock) disable iff (rst)
        wr_en && hit(addr, psod_pkg::ADDR_MON_ENABLE) |=> mon_enable == $past(wdata))
        else $error("monitor control write lost");
    pair01_a: assert property (@(posedge clock) disable iff (rst)
        drv_hit[0] |=> ##1 channel_power_down[1:0] == {2{$past(wdata[4], 2)}})
        else $error("pair 0-1 power-down wrong");
    // channels zero and one always move together
    pair01_eq_a: assert property (@(posedge clock) disable iff (rst)
        channel_power_down[0] == channel_power_down[1])
        else $error("pair 0-1 split");
    pair23_a: assert property (@(posedge clock) disable iff (rst)
        drv_hit[2] |=> ##1 channel_power_down[3:2] == {2{$past(wdata[4], 2)}})
        else $error("pair 2-3 power-down wrong");
    // channels two and three always move together
    pair23_eq_a: assert property (@(posedge clock) disable iff (rst)
        channel_power_down[2] == channel_power_down[3])
        else $error("pair 2-3 split");
    swing_a: assert property (@(posedge clock) disable iff (rst)
        drv_hit[1] |=> ##1 drv_swing[3:2] == $past(wdata[2:1], 2))
        else $error("swing wrong");
    drv_pd_a: assert property (@(posedge clock) disable iff (rst)
        drv_hit[0] |=> ##1 drv_power_down[0] == $past(wdata[0], 2))
        else $error("driver power-down wrong");
    auto_sw_a: assert property (@(posedge clock) disable iff (rst)
        pd_q[5] |=> !auto_switch_allowed)
        else $error("switchover allowed with monitor clock off");
    // switchover allowed once both monitor clocks run
    auto_on_a: assert property (@(posedge clock) disable iff (rst)
        !pd_q[5] && !pd_q[4] |=> auto_switch_allowed)
        else $error("switchover blocked with monitor clocks on");
    pd_wr_a: assert property (@(posedge clock) disable iff (rst)
        wr_en && hit(addr, psod_pkg::ADDR_POWER_DOWN) |=> power_down_ctrl == $past(wdata))
        else $error("power-down control write lost");

    // Main scenarios: status read, pair power-down, top swing, switchover, presence
    status_rd_c: cover property (@(posedge clock) stat_rd);
    pair_pd_c: cover property (@(posedge clock) channel_power_down == 4'hF);
    swing_max_c: cover property (@(posedge clock) drv_swing[1:0] == psod_pkg::SWING_960MV);
    auto_on_c: cover property (@(posedge clock) auto_switch_allowed);
    reference_input_second_seen_c: cover property (@(posedge clock) stat_rd && reference_input_second_valid && st.ref_second_present);
endmodule
`default_nettype wire

// File: verification/psod_testbench.sv
// Self-checking bench for the PLL status and output driver register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clock;
    logic rst;
    logic wr_en;
    logic rd_en;
    logic [9:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    psod_pkg::psod_status_type status_in;
    logic [2:0] drv_power_down;
    logic [5:0] drv_swing;
    logic [3:0] channel_power_down;
    logic [7:0] mon_enable;
    logic [7:0] power_down_ctrl;
    logic auto_switch_allowed;
    int err_total;
    int n_compared;

    psod_regs #(.NUM_DRIVERS(3)) uut (
        .clock(clock),
        .rst(rst),
        .wr_en(wr_en),
        .rd_en(rd_en),
        .addr(addr),
        .wdata(wdata),
        .rdata(rdata),
        .status_in(status_in),
        .drv_power_down(drv_power_down),
        .drv_swing(drv_swing),
        .channel_power_down(channel_power_down),
        .mon_enable(mon_enable),
        .power_down_ctrl(power_down_ctrl),
        .auto_switch_allowed(auto_switch_allowed)
    );

    // Free-running port clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Case equality, so an unknown never passes
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One-cycle write strobe, dropped at the edge that takes it
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask

    // Read data is registered, so look just after the taking edge
    task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic close_out;
        $display("Compared %0d values, %0d mismatches", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Watchdog: the whole sequence needs well under 1000 cycles
    initial begin
        #200000;
        err_total++;
        close_out();
    end

    initial begin
        logic [4:0] st [3];
        err_total = 0;
        n_compared = 0;
        rst = 1'b1;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 10'h000;
        wdata = 8'h00;
        status_in = psod_pkg::psod_status_type'(5'h1F);
        st = '{5'h15, 5'h0A, 5'h00};
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        settle(2);
        // Reset state of drivers and monitor controls
        chk({2'h0, drv_swing}, 8'h2A);
        chk({5'h00, drv_power_down}, 8'h00);
        chk({4'h0, channel_power_down}, 8'h00);
        chk(power_down_ctrl, 8'h22);
        chk({7'h00, auto_switch_allowed}, 8'h00);
        for (int i = 0; i < 3; i++) begin
            rd_chk(10'h0F0 + 10'(i), 8'h04);
        end
        // Presence bits hidden until monitors run; lock and select always shown
        settle(6);
        rd_chk(psod_pkg::ADDR_PLL_STATUS, 8'h11);
        wr(psod_pkg::ADDR_MON_ENABLE, 8'hE0);
        settle(6);
        chk(mon_enable, 8'hE0);
        rd_chk(psod_pkg::ADDR_PLL_STATUS, 8'h1B);
        wr(psod_pkg::ADDR_POWER_DOWN, 8'h12);
        settle(2);
        chk({7'h00, auto_switch_allowed}, 8'h00);
        rd_chk(psod_pkg::ADDR_PLL_STATUS, 8'h1D);
        wr(psod_pkg::ADDR_POWER_DOWN, 8'h02);
        settle(2);
        chk({7'h00, auto_switch_allowed}, 8'h01);
        rd_chk(psod_pkg::ADDR_PLL_STATUS, 8'h1F);
        chk(power_down_ctrl, 8'h02);
        rd_chk(psod_pkg::ADDR_MON_ENABLE, 8'hE0);
        rd_chk(psod_pkg::ADDR_POWER_DOWN, 8'h02);
        // Each status field follows its own input once qualified
        for (int i = 0; i < 3; i++) begin
            status_in <= psod_pkg::psod_status_type'(st[i]);
            settle(6);
            rd_chk(psod_pkg::ADDR_PLL_STATUS, {3'h0, st[i]});
        end
        // Status is read-only; unmapped places read zero
        wr(psod_pkg::ADDR_PLL_STATUS, 8'hFF);
        rd_chk(psod_pkg::ADDR_PLL_STATUS, 8'h00);
        wr(10'h100, 8'h5A);
        rd_chk(10'h100, 8'h00);
        // Pair power-down plus single driver power-down on driver zero
        wr(psod_pkg::ADDR_DRV_ZERO, 8'h11);
        settle(2);
        chk({4'h0, channel_power_down}, 8'h03);
        chk({5'h00, drv_power_down}, 8'h01);
        rd_chk(psod_pkg::ADDR_DRV_ZERO, 8'h11);
        // All four swing codes on driver one, reserved bit kept at 0
        for (int c = 0; c < 4; c++) begin
            wr(psod_pkg::ADDR_DRV_ONE, {5'h00, 2'(c), 1'b0});
            settle(2);
            chk({6'h00, drv_swing[3:2]}, 8'(c));
            rd_chk(psod_pkg::ADDR_DRV_ONE, {5'h00, 2'(c), 1'b0});
        end
        // Driver two with don't-care bits set, then its pair power-down
        wr(psod_pkg::ADDR_DRV_TWO, 8'hE9);
        settle(2);
        chk({5'h00, drv_power_down}, 8'h05);
        chk({4'h0, channel_power_down}, 8'h03);
        chk({6'h00, drv_swing[5:4]}, 8'h00);
        wr(psod_pkg::ADDR_DRV_TWO, 8'h17);
        settle(2);
        chk({4'h0, channel_power_down}, 8'h0F);
        chk({6'h00, drv_swing[5:4]}, 8'h03);
        wr(psod_pkg::ADDR_DRV_ZERO, 8'h04);
        settle(2);
        chk({4'h0, channel_power_down}, 8'h0C);
        chk({5'h00, drv_power_down}, 8'h04);
        // Driver one single power-down, then a reset in mid-run
        wr(psod_pkg::ADDR_DRV_ONE, 8'h05);
        settle(2);
        chk({5'h00, drv_power_down}, 8'h06);
        chk({6'h00, drv_swing[3:2]}, 8'h02);
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        settle(2);
        chk({2'h0, drv_swing}, 8'h2A);
        chk({5'h00, drv_power_down}, 8'h00);
        chk({4'h0, channel_power_down}, 8'h00);
        chk(mon_enable, 8'h00);
        chk(power_down_ctrl, 8'h22);
        rd_chk(psod_pkg::ADDR_DRV_TWO, 8'h04);
        close_out();
    end
endmodule
`default_nettype wire
